// ---- hw/rrte_cfg.svh ----
// offsets, opcodes and reset values of the register and RAM transfer executor
`ifndef RRTE_CFG_SVH
`define RRTE_CFG_SVH

// register byte offsets on the bus
`define RRTE_OFF_INSTR    8'h00
`define RRTE_OFF_ACC      8'h04
`define RRTE_OFF_B        8'h08
`define RRTE_OFF_XADDR    8'h0C
`define RRTE_OFF_YADDR    8'h10
`define RRTE_OFF_ZADDR    8'h14
`define RRTE_OFF_D        8'h18
`define RRTE_OFF_E        8'h1C
`define RRTE_OFF_STACK_PTR 8'h20
`define RRTE_OFF_STATUS   8'h24
`define RRTE_OFF_RAM_ADDR 8'h28
`define RRTE_OFF_RAM_DATA 8'h2C

// status register bit positions
`define RRTE_ST_CARRY     0
`define RRTE_ST_SKIP      1
`define RRTE_ST_LAST_LOAD_XY 2

// fixed 10-bit opcodes
`define RRTE_OP_ACC_FROM_B      10'h01E
`define RRTE_OP_B_FROM_ACC      10'h00E
`define RRTE_OP_ACC_FROM_YADDR  10'h01F
`define RRTE_OP_YADDR_FROM_ACC  10'h00C
`define RRTE_OP_PACK_TO_E       10'h01A
`define RRTE_OP_UNPACK_FROM_E   10'h02A
`define RRTE_OP_D_FROM_ACC      10'h029
`define RRTE_OP_ACC_FROM_D      10'h051
`define RRTE_OP_ACC_FROM_ZADDR  10'h053
`define RRTE_OP_ACC_FROM_XADDR  10'h052
`define RRTE_OP_ACC_FROM_STACK_PTR 10'h050
`define RRTE_OP_INC_YADDR       10'h013
`define RRTE_OP_DEC_YADDR       10'h017

// opcode prefixes: load_x_and_y uses bits 9:8, load_zaddr bits 9:2, ram ops bits 9:4
`define RRTE_PFX_LOAD_X_AND_Y   2'h3
`define RRTE_PFX_LOAD_ZADDR     8'h12
`define RRTE_PFX_RAM_TO_ACC     6'h2C
`define RRTE_PFX_SWAP           6'h2D
`define RRTE_PFX_SWAP_DEC       6'h2F
`define RRTE_PFX_SWAP_INC       6'h2E
`define RRTE_PFX_ACC_TO_RAM     6'h2B

// wrap values that request a skip
`define RRTE_INC_WRAP           4'h0
`define RRTE_DEC_WRAP           4'hF

`define RRTE_RST_NIBBLE         4'h0
`endif

// ---- hw/rrte_pkg.sv ----
// types of the register and RAM transfer executor
package rrte_pkg;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} rrte_aph_t;

	typedef struct packed {
		logic [3:0]  acc;
		logic [3:0]  b;
		logic [3:0]  xaddr;
		logic [3:0]  yaddr;
		logic [1:0]  zaddr;
		logic [2:0]  d;
		logic [7:0]  e;
		logic [2:0]  stack_pointer;
		logic        carry_flag;
		logic        skip;
		logic        last_load_xy;
		logic [9:0]  instr;
		logic [9:0]  ram_addr;
		logic        wr_pend;
		logic        rd_pend;
		logic [7:0]  dph_addr;
		logic [31:0] hrdata;
	} rrte_state_t;

endpackage : rrte_pkg

// ---- hw/rrte_exec.sv ----
// executor for register, RAM address and RAM transfer instructions behind an AHB-Lite slave
//
// Register access over AHB-Lite and the placing of the registers were decided locally.
`include "rrte_cfg.svh"

// Overview of operation
// RULE1 - acc takes B; B, carry untouched
// RULE2 - B takes acc; carry untouched
// RULE3 - acc takes Y; Y, carry untouched
// RULE4 - Y takes acc; carry untouched
// RULE5 - E high gets B, low gets acc
// RULE6 - B gets E high, acc E low
// RULE7 - D takes acc bits 2..0
// RULE8 - acc gets D, bit 3 cleared
// RULE9 - acc gets Z, bits 3..2 cleared
// RULE10 - acc takes X; carry untouched
// RULE11 - acc gets stack pointer, bit 3 cleared
// RULE12 - load X and Y from immediates
// RULE13 - consecutive X/Y loads: only first executes
// RULE14 - load Z from 2-bit immediate
// RULE15 - increment Y, skip next on 0
// RULE16 - decrement Y, skip next on 15
// RULE17 - acc from RAM, then X xor j
// RULE18 - swap RAM and acc, X xor j
// RULE19 - swap, X xor j, dec Y skip 15
// RULE20 - swap, X xor j, inc Y skip 0
// RULE21 - store acc to RAM, X xor j
// RULE22 - skipped instruction only updates instr and last_load_xy and clears skip
module rrte_exec
	import rrte_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp
);

	localparam int RAM_WORDS = 1024;

	rrte_state_t s;
	rrte_state_t next_s;
	rrte_aph_t   aph;

	logic [3:0] ram [RAM_WORDS];
	logic       ram_we;
	logic [9:0] ram_waddr;
	logic [3:0] ram_wdata;
	logic [9:0] data_pointer;
	logic [3:0] ram_at_data_pointer;

	// data pointer is bank Z, row X, column Y
	assign data_pointer        = {s.zaddr, s.xaddr, s.yaddr};
	assign ram_at_data_pointer = ram[data_pointer];

	assign aph.valid = hsel & htrans[1] & hready;
	assign aph.write = hwrite;
	assign aph.addr  = haddr[7:0];

	// reads take one wait state so that read data comes from a flop
	assign hreadyout = ~s.rd_pend;
	assign hresp     = 1'b0;
	assign hrdata    = s.hrdata;

	function automatic logic [31:0] read_reg(input rrte_state_t st, input logic [7:0] a,
		input logic [3:0] rdat);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			`RRTE_OFF_INSTR:    r[9:0] = st.instr;
			`RRTE_OFF_ACC:      r[3:0] = st.acc;
			`RRTE_OFF_B:        r[3:0] = st.b;
			`RRTE_OFF_XADDR:    r[3:0] = st.xaddr;
			`RRTE_OFF_YADDR:    r[3:0] = st.yaddr;
			`RRTE_OFF_ZADDR:    r[1:0] = st.zaddr;
			`RRTE_OFF_D:        r[2:0] = st.d;
			`RRTE_OFF_E:        r[7:0] = st.e;
			`RRTE_OFF_STACK_PTR: r[2:0] = st.stack_pointer;
			`RRTE_OFF_STATUS: begin
				r[`RRTE_ST_CARRY] = st.carry_flag;
				r[`RRTE_ST_SKIP]  = st.skip;
				r[`RRTE_ST_LAST_LOAD_XY] = st.last_load_xy;
			end
			`RRTE_OFF_RAM_ADDR: r[9:0] = st.ram_addr;
			`RRTE_OFF_RAM_DATA: r[3:0] = rdat;
			default:            r = 32'h0000_0000;
		endcase
		return r;
	endfunction : read_reg

	always_comb begin
		logic [9:0] op;
		logic       is_load_xy;
		logic [3:0] j;
		logic [3:0] y_inc;
		logic [3:0] y_dec;
		next_s    = s;
		ram_we    = 1'b0;
		ram_waddr = s.ram_addr;
		ram_wdata = hwdata[3:0];
		op        = hwdata[9:0];
		j         = op[3:0];
		is_load_xy = (op[9:8] == `RRTE_PFX_LOAD_X_AND_Y);
		y_inc     = s.yaddr + 4'h1;
		y_dec     = s.yaddr - 4'h1;

		next_s.wr_pend = 1'b0;
		next_s.rd_pend = 1'b0;

		if (s.rd_pend) begin
			next_s.hrdata = read_reg(s, s.dph_addr, ram[s.ram_addr]);
		end

		if (s.wr_pend) begin
			case (s.dph_addr)
				`RRTE_OFF_INSTR: begin
					next_s.instr    = op;
					next_s.last_load_xy = is_load_xy;
					if (s.skip || (is_load_xy && s.last_load_xy)) begin
						next_s.skip = 1'b0; // [RULE22] [RULE13]
					end else begin
						next_s.skip = 1'b0;
						if (is_load_xy) begin
							next_s.xaddr = op[7:4]; // [RULE12]
							next_s.yaddr = op[3:0]; // [RULE12]
						end else if (op[9:2] == `RRTE_PFX_LOAD_ZADDR) begin
							next_s.zaddr = op[1:0]; // [RULE14]
						end else begin
							case (op[9:4])
								`RRTE_PFX_RAM_TO_ACC: begin
									next_s.acc   = ram_at_data_pointer; // [RULE17]
									next_s.xaddr = s.xaddr ^ j; // [RULE17]
								end
								`RRTE_PFX_SWAP, `RRTE_PFX_SWAP_DEC, `RRTE_PFX_SWAP_INC: begin
									next_s.acc   = ram_at_data_pointer; // [RULE18]
									ram_we       = 1'b1; // [RULE18]
									ram_waddr    = data_pointer;
									ram_wdata    = s.acc;
									next_s.xaddr = s.xaddr ^ j; // [RULE18]
									if (op[9:4] == `RRTE_PFX_SWAP_DEC) begin
										next_s.yaddr = y_dec; // [RULE19]
										next_s.skip  = (y_dec == `RRTE_DEC_WRAP); // [RULE19]
									end else if (op[9:4] == `RRTE_PFX_SWAP_INC) begin
										next_s.yaddr = y_inc; // [RULE20]
										next_s.skip  = (y_inc == `RRTE_INC_WRAP); // [RULE20]
									end
								end
								`RRTE_PFX_ACC_TO_RAM: begin
									ram_we       = 1'b1; // [RULE21]
									ram_waddr    = data_pointer;
									ram_wdata    = s.acc;
									next_s.xaddr = s.xaddr ^ j; // [RULE21]
								end
								default: begin
									case (op)
										`RRTE_OP_ACC_FROM_B:     next_s.acc = s.b; // [RULE1]
										`RRTE_OP_B_FROM_ACC:     next_s.b = s.acc; // [RULE2]
										`RRTE_OP_ACC_FROM_YADDR: next_s.acc = s.yaddr; // [RULE3]
										`RRTE_OP_YADDR_FROM_ACC: next_s.yaddr = s.acc; // [RULE4]
										`RRTE_OP_PACK_TO_E:      next_s.e = {s.b, s.acc}; // [RULE5]
										`RRTE_OP_UNPACK_FROM_E: begin
											next_s.b   = s.e[7:4]; // [RULE6]
											next_s.acc = s.e[3:0]; // [RULE6]
										end
										`RRTE_OP_D_FROM_ACC:     next_s.d = s.acc[2:0]; // [RULE7]
										`RRTE_OP_ACC_FROM_D:     next_s.acc = {1'b0, s.d}; // [RULE8]
										`RRTE_OP_ACC_FROM_ZADDR: next_s.acc = {2'b00, s.zaddr}; // [RULE9]
										`RRTE_OP_ACC_FROM_XADDR: next_s.acc = s.xaddr; // [RULE10]
										`RRTE_OP_ACC_FROM_STACK_PTR: begin
											next_s.acc = {1'b0, s.stack_pointer}; // [RULE11]
										end
										`RRTE_OP_INC_YADDR: begin
											next_s.yaddr = y_inc; // [RULE15]
											next_s.skip  = (y_inc == `RRTE_INC_WRAP); // [RULE15]
										end
										`RRTE_OP_DEC_YADDR: begin
											next_s.yaddr = y_dec; // [RULE16]
											next_s.skip  = (y_dec == `RRTE_DEC_WRAP); // [RULE16]
										end
										default: next_s.instr = op;
									endcase
								end
							endcase
						end
					end
				end
				`RRTE_OFF_ACC:      next_s.acc = hwdata[3:0];
				`RRTE_OFF_B:        next_s.b = hwdata[3:0];
				`RRTE_OFF_XADDR:    next_s.xaddr = hwdata[3:0];
				`RRTE_OFF_YADDR:    next_s.yaddr = hwdata[3:0];
				`RRTE_OFF_ZADDR:    next_s.zaddr = hwdata[1:0];
				`RRTE_OFF_D:        next_s.d = hwdata[2:0];
				`RRTE_OFF_E:        next_s.e = hwdata[7:0];
				`RRTE_OFF_STACK_PTR: next_s.stack_pointer = hwdata[2:0];
				`RRTE_OFF_STATUS: begin
					next_s.carry_flag = hwdata[`RRTE_ST_CARRY];
					next_s.skip       = hwdata[`RRTE_ST_SKIP];
					next_s.last_load_xy = hwdata[`RRTE_ST_LAST_LOAD_XY];
				end
				`RRTE_OFF_RAM_ADDR: next_s.ram_addr = hwdata[9:0];
				`RRTE_OFF_RAM_DATA: ram_we = 1'b1;
				default:            next_s.instr = s.instr;
			endcase
		end

		if (aph.valid) begin
			next_s.dph_addr = aph.addr;
			next_s.wr_pend  = aph.write;
			next_s.rd_pend  = ~aph.write;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// RAM holds no reset; contents are undefined until written
	always_ff @(posedge hclk) begin
		if (ram_we) begin
			ram[ram_waddr] <= ram_wdata;
		end
	end

endmodule : rrte_exec

// ---- sim/rrte_exec_properties.sv ----
// bus timing and register width properties of the transfer executor
module rrte_exec_properties
	import rrte_pkg::*;
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp
);
	logic rd_req;
	logic wr_req;
	assign rd_req = hsel & htrans[1] & hready & ~hwrite;
	assign wr_req = hsel & htrans[1] & hready & hwrite;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence rd_s(o);
		rd_req ##0 haddr[7:0] == o;
	endsequence
	okay_resp_a: assert property (hresp == 1'b0) else $error("response not okay");
	wr_no_wait_a: assert property (wr_req |=> hreadyout) else $error("write stalled");
	rd_one_wait_a: assert property (rd_req |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	stall_cause_a: assert property ($fell(hreadyout) |-> $past(rd_req))
		else $error("stall without read");
	rd_hold_a: assert property ($changed(hrdata) |-> $past(hreadyout) == 1'b0)
		else $error("read data moved outside a read");
	acc_width_a: assert property (rd_s(8'h04) |-> ##2 hrdata[31:4] == '0)
		else $error("acc wider than a nibble");
	d_width_a: assert property (rd_s(8'h18) |-> ##2 hrdata[31:3] == '0)
		else $error("d wider than 3 bits");
	z_width_a: assert property (rd_s(8'h14) |-> ##2 hrdata[31:2] == '0)
		else $error("z wider than 2 bits");
	e_width_a: assert property (rd_s(8'h1C) |-> ##2 hrdata[31:8] == '0)
		else $error("e wider than 8 bits");
	stack_width_a: assert property (rd_s(8'h20) |-> ##2 hrdata[31:3] == '0)
		else $error("stack pointer wider than 3 bits");
endmodule : rrte_exec_properties

bind rrte_exec rrte_exec_properties i_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp);

// ---- sim/test_register_ram_transfer_exec.sv ----
// self-checking bench of the register and RAM transfer executor
module test_register_ram_transfer_exec;
	timeunit 1ns;
	timeprecision 100ps;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	int          n_fail = 0;
	int          n_compared = 0;
	// pre acc, opcode, offset checked, expected
	logic [29:0] t [11] = '{{4'hF, 10'h01E, 8'h04, 8'h0A},
		{4'hF, 10'h051, 8'h04, 8'h05},
		{4'hF, 10'h053, 8'h04, 8'h02},
		{4'hF, 10'h052, 8'h04, 8'h03},
		{4'hF, 10'h050, 8'h04, 8'h04},
		{4'hF, 10'h01F, 8'h04, 8'h06},
		{4'hF, 10'h02A, 8'h08, 8'h0C},
		{4'h3, 10'h01A, 8'h1C, 8'hC3},
		{4'h9, 10'h00E, 8'h08, 8'h09},
		{4'hB, 10'h029, 8'h18, 8'h03},
		{4'h7, 10'h00C, 8'h10, 8'h07}};
	// pre y, opcode, expected y, skip expected
	logic [18:0] s [4] = '{{4'hF, 10'h013, 4'h0, 1'b1}, {4'h0, 10'h017, 4'hF, 1'b1},
		{4'h3, 10'h013, 4'h4, 1'b0}, {4'h5, 10'h017, 4'h4, 1'b0}};

	rrte_exec i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

	initial begin
		forever #12.5 hclk = ~hclk;
	end

	task automatic chk(input logic [31:0] v, input logic [31:0] e);
		n_compared++;
		if (v !== e) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, v, e);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask : rc

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up

	initial begin
		#1000000;
		n_fail++;
		wrap_up();
	end

	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rc(8'h04, 32'h0);
		wr(8'h40, 32'hFF);
		rc(8'h40, 32'h0);
		$display("reset and decode test done");
		wr(8'h08, 32'hA);
		wr(8'h0C, 32'h3);
		wr(8'h10, 32'h6);
		wr(8'h14, 32'h2);
		wr(8'h18, 32'h5);
		wr(8'h1C, 32'hC9);
		wr(8'h20, 32'h4);
		rc(8'h20, 32'h4);
		wr(8'h24, 32'h1);
		for (int i = 0; i < 11; i++) begin
			wr(8'h04, 32'(t[i][29:26]));
			wr(8'h00, 32'(t[i][25:16]));
			rc(t[i][15:8], 32'(t[i][7:0]));
		end
		rc(8'h24, 32'h1);
		$display("transfer test done");
		for (int i = 0; i < 4; i++) begin
			wr(8'h10, 32'(s[i][18:15]));
			wr(8'h04, 32'hF);
			wr(8'h00, 32'(s[i][14:5]));
			rc(8'h10, 32'(s[i][4:1]));
			rc(8'h24, {30'h0, s[i][0], 1'b1});
			wr(8'h00, 32'h01E);
			rc(8'h04, s[i][0] ? 32'hF : 32'h9);
		end
		$display("step and skip test done");
		wr(8'h00, 32'h3A5);
		rc(8'h0C, 32'hA);
		wr(8'h00, 32'h312);
		rc(8'h0C, 32'hA);
		rc(8'h10, 32'h5);
		wr(8'h00, 32'h04B);
		rc(8'h14, 32'h3);
		wr(8'h00, 32'h3C7);
		rc(8'h10, 32'h7);
		$display("address load test done");
		wr(8'h00, 32'h049);
		wr(8'h0C, 32'h2);
		wr(8'h10, 32'h3);
		wr(8'h28, 32'h123);
		wr(8'h2C, 32'h6);
		wr(8'h04, 32'h9);
		wr(8'h00, 32'h2C5);
		rc(8'h04, 32'h6);
		rc(8'h0C, 32'h7);
		wr(8'h00, 32'h2B5);
		rc(8'h0C, 32'h2);
		wr(8'h28, 32'h173);
		rc(8'h2C, 32'h6);
		wr(8'h04, 32'h1);
		wr(8'h00, 32'h2D0);
		rc(8'h04, 32'h6);
		rc(8'h10, 32'h3);
		wr(8'h28, 32'h123);
		rc(8'h2C, 32'h1);
		wr(8'h10, 32'h0);
		wr(8'h28, 32'h120);
		wr(8'h2C, 32'hA);
		wr(8'h00, 32'h2F1);
		rc(8'h04, 32'hA);
		rc(8'h0C, 32'h3);
		rc(8'h10, 32'hF);
		rc(8'h24, 32'h3);
		rc(8'h2C, 32'h6);
		wr(8'h24, 32'h1);
		wr(8'h28, 32'h13F);
		wr(8'h2C, 32'h5);
		wr(8'h00, 32'h2E1);
		rc(8'h04, 32'h5);
		rc(8'h10, 32'h0);
		rc(8'h24, 32'h3);
		wr(8'h00, 32'h2B4);
		rc(8'h0C, 32'h2);
		wr(8'h28, 32'h120);
		rc(8'h2C, 32'h6);
		$display("ram transfer test done");
		wrap_up();
	end
endmodule : test_register_ram_transfer_exec
